// ==== hdl/tofc_command_handler.sv ====
`timescale 1ns/10ps
// Behaviour
// - arg one: pin masks bits 1:0, values 3:2
// - change address only when masked pins match
// - arg two bits 7:1 hold new address
// - codes 0x80..0x93 load channel quarter window
// - after window read transaction, refill next data
// - every refill updates contents and transaction ID
// - after last quarter, advance channel number
// - stop command returns device to idle
// - stop waits for current state to finish
// - stop ends continuous measurement
// - last command register reports executed command
// - contents reads selected channel quarter code
module tofc_command_handler
  import tofc_pkg::*;
#(
  parameter int WIN_BYTES = 128,
  parameter int CHANNELS = 5,
  parameter logic [7:0] MINOR_REV = 8'h01 // arbitrary value
)
(
  input wire logic mclk_i,
  input wire logic reset_n_i,
  input wire logic ce_i,
  input wire tofc_reg_req_type reg_req_i,
  input wire logic xact_end_i,
  output logic [7:0] rdata_o,
  output logic [6:0] bus_addr_o,
  input wire logic aux_pin_zero_i,
  input wire logic aux_pin_one_i,
  output logic hist_req_o,
  output logic [7:0] hist_sel_o,
  input wire logic hist_valid_i,
  input wire logic [7:0] hist_data_i,
  output logic hist_ready_o,
  output logic meas_start_o,
  output logic [7:0] meas_cmd_o,
  output logic meas_stop_o,
  input wire logic meas_done_i
);

  // ---------------------------------------------------------------
  // elaboration checks
  // ---------------------------------------------------------------
  if (WIN_BYTES != 128)
    $error("window must span 0x20..0x9F");
  if (CHANNELS < 1 || CHANNELS > 5)
    $error("channel count must be 1..5");

  function automatic logic in_window(input logic [7:0] a);
    in_window = (a >= WIN_FIRST) && (a <= WIN_LAST);
  endfunction : in_window

  tofc_state_type state_q;
  logic [7:0] command_entry_q, arg_first_q, arg_second_q, last_command_code_q;
  logic [7:0] contents_q, tid_q, cmd_code_q;
  logic cmd_pend_q, stop_pend_q, match_q, win_read_q;
  logic [2:0] time_converter_channel_q;
  logic [1:0] quarter_q;
  logic [6:0] fill_idx_q;
  logic [7:0] win_mem [WIN_BYTES];
  logic [1:0] pins;
  logic take, fill_beat, fill_last, show_end, is_hist, pin_match;

  tofc_pin_sync #(.WIDTH(2)) u_sync (
    .mclk_i(mclk_i),
    .reset_n_i(reset_n_i),
    .ce_i(ce_i),
    .async_i({aux_pin_one_i, aux_pin_zero_i}),
    .sync_o(pins)
  );

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  // masks in bits 1:0, expected levels in 3:2
  // masked pin compare, pin one in the upper place
  assign pin_match = {arg_first_q[MASK1_BIT] & pins[1], arg_first_q[MASK0_BIT] & pins[0]}
    == {arg_first_q[VAL1_BIT], arg_first_q[VAL0_BIT]};
  assign take = cmd_pend_q && ((state_q == ST_IDLE) || (state_q == ST_SHOW));
  assign is_hist = (cmd_code_q >= CMD_HIST_FIRST) && (cmd_code_q <= CMD_HIST_LAST);
  assign fill_beat = (state_q == ST_FILL) && hist_valid_i;
  assign fill_last = fill_beat && (fill_idx_q == 7'(WIN_BYTES - 1));
  assign show_end = (state_q == ST_SHOW) && xact_end_i && win_read_q && !cmd_pend_q;
  assign hist_req_o = (state_q == ST_FILL);
  assign hist_ready_o = (state_q == ST_FILL);
  assign hist_sel_o = CMD_HIST_FIRST | {3'h0, time_converter_channel_q, quarter_q};
  // stop asks the engine to end continuous runs
  assign meas_stop_o = (state_q == ST_MEAS) && stop_pend_q;

  // ---------------------------------------------------------------
  // host registers
  // ---------------------------------------------------------------
  // argument bytes and the command entry, write only from host
  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      command_entry_q <= RESET_BYTE;
      arg_first_q <= RESET_BYTE;
      arg_second_q <= RESET_BYTE;
    end
    else if (ce_i && reg_req_i.wr)
    begin
      if (reg_req_i.addr == REG_COMMAND)
        command_entry_q <= reg_req_i.wdata;
      if (reg_req_i.addr == REG_ARG_FIRST)
        arg_first_q <= reg_req_i.wdata; // zero gives unconditional change
      if (reg_req_i.addr == REG_ARG_SECOND)
        arg_second_q <= reg_req_i.wdata;
    end
  end

  // pending flags; a new write wins over the clear by take
  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      cmd_pend_q <= 1'b0;
      stop_pend_q <= 1'b0;
      cmd_code_q <= RESET_BYTE;
    end
    else if (ce_i)
    begin
      if (reg_req_i.wr && reg_req_i.addr == REG_COMMAND && reg_req_i.wdata == CMD_STOP)
        stop_pend_q <= 1'b1;
      else if (state_q == ST_IDLE)
        stop_pend_q <= 1'b0;
      if (reg_req_i.wr && reg_req_i.addr == REG_COMMAND && reg_req_i.wdata != CMD_STOP)
      begin
        cmd_pend_q <= 1'b1;
        cmd_code_q <= reg_req_i.wdata;
      end
      else if (take || stop_pend_q)
        cmd_pend_q <= 1'b0; // stop discards a queued command
    end
  end

  // read data is registered, valid the cycle after rd
  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      rdata_o <= RESET_BYTE;
    else if (ce_i && reg_req_i.rd)
    begin
      if (in_window(reg_req_i.addr))
        rdata_o <= win_mem[7'(reg_req_i.addr - WIN_FIRST)];
      else
        unique case (reg_req_i.addr)
          REG_ARG_SECOND: rdata_o <= arg_second_q;
          REG_ARG_FIRST: rdata_o <= arg_first_q;
          REG_COMMAND: rdata_o <= command_entry_q;
          REG_LAST_CMD: rdata_o <= last_command_code_q;
          REG_MINOR_REV: rdata_o <= MINOR_REV;
          REG_CONTENTS: rdata_o <= contents_q;
          REG_TID: rdata_o <= tid_q;
          default: rdata_o <= RESET_BYTE;
        endcase
    end
  end

  // ---------------------------------------------------------------
  // command sequencer
  // ---------------------------------------------------------------
  // stop always lands in idle
  // stop is checked only where a state ends
  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      state_q <= ST_IDLE;
    else if (ce_i)
      unique case (state_q)
        ST_IDLE, ST_SHOW:
        begin
          if (stop_pend_q)
            state_q <= ST_IDLE;
          else if (take && cmd_code_q == CMD_ADDR_CHANGE)
            state_q <= ST_ADDR;
          else if (take && is_hist)
            state_q <= ST_FILL;
          else if (take)
            state_q <= ST_MEAS;
          else if (show_end)
            state_q <= ST_FILL;
        end
        ST_ADDR:
          if (xact_end_i)
            state_q <= ST_IDLE;
        ST_FILL:
          if (fill_last)
            state_q <= stop_pend_q ? ST_IDLE : ST_SHOW;
        ST_MEAS:
          if (meas_done_i)
            state_q <= ST_IDLE;
        default:
          state_q <= ST_IDLE;
      endcase
  end

  // hand other commands to the measurement engine
  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      meas_start_o <= 1'b0;
      meas_cmd_o <= RESET_BYTE;
    end
    else if (ce_i)
    begin
      meas_start_o <= take && !stop_pend_q && !is_hist && cmd_code_q != CMD_ADDR_CHANGE;
      if (take)
        meas_cmd_o <= cmd_code_q;
    end
  end

  // code recorded when executed; stays during continuous runs
  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      last_command_code_q <= RESET_BYTE;
    else if (ce_i)
    begin
      if (take && !stop_pend_q)
        last_command_code_q <= cmd_code_q;
      else if (stop_pend_q && state_q == ST_IDLE)
        last_command_code_q <= CMD_STOP;
    end
  end

  // ---------------------------------------------------------------
  // bus address change
  // ---------------------------------------------------------------
  // compare is taken when the command starts
  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      match_q <= 1'b0;
    else if (ce_i && take)
      match_q <= pin_match;
  end

  // the old address serves until the transaction closes
  // bit 0 of the second argument is ignored
  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      bus_addr_o <= ADDR_RESET;
    else if (ce_i && state_q == ST_ADDR && xact_end_i && match_q)
      bus_addr_o <= arg_second_q[7:NEW_ADDR_LSB];
  end

  // ---------------------------------------------------------------
  // histogram window
  // ---------------------------------------------------------------
  // channel and quarter taken from the code
  // channel steps after its last quarter
  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      time_converter_channel_q <= 3'h0;
      quarter_q <= 2'h0;
    end
    else if (ce_i)
    begin
      if (take && is_hist && !stop_pend_q)
      begin
        time_converter_channel_q <= cmd_code_q[HIST_CH_MSB:HIST_CH_LSB];
        quarter_q <= cmd_code_q[HIST_Q_MSB:0];
      end
      else if (show_end && !stop_pend_q)
      begin
        quarter_q <= quarter_q + 2'h1;
        if (quarter_q == LAST_QUARTER)
          time_converter_channel_q <= (time_converter_channel_q == 3'(CHANNELS - 1)) ? 3'h0
            : time_converter_channel_q + 3'h1;
      end
    end
  end

  // a read of the window arms the refill at transaction end
  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      win_read_q <= 1'b0;
    else if (ce_i)
    begin
      if (state_q != ST_SHOW)
        win_read_q <= 1'b0;
      else if (reg_req_i.rd && in_window(reg_req_i.addr))
        win_read_q <= 1'b1;
      else if (xact_end_i)
        win_read_q <= 1'b0;
    end
  end

  // window bytes arrive one per beat; no reset, storage only
  always_ff @(posedge mclk_i)
  begin
    if (ce_i && fill_beat)
      win_mem[fill_idx_q] <= hist_data_i;
  end

  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      fill_idx_q <= 7'h00;
    else if (ce_i)
      fill_idx_q <= (state_q != ST_FILL) ? 7'h00 : (fill_beat ? fill_idx_q + 7'h01 : fill_idx_q);
  end

  // contents and ID change together with the window
  // contents carries the channel quarter code
  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      contents_q <= RESET_BYTE;
      tid_q <= RESET_BYTE;
    end
    else if (ce_i && fill_last)
    begin
      contents_q <= hist_sel_o;
      tid_q <= tid_q + 8'h01;
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  property p_addr_apply;
    @(posedge mclk_i) disable iff (!reset_n_i)
    ce_i && state_q == ST_ADDR && xact_end_i && match_q |=> bus_addr_o == $past(arg_second_q[7:1]);
  endproperty
  a_addr_apply: assert property (p_addr_apply) else $error("address not applied");

  property p_addr_hold;
    @(posedge mclk_i) disable iff (!reset_n_i)
    !(ce_i && state_q == ST_ADDR && xact_end_i && match_q) |=> $stable(bus_addr_o);
  endproperty
  a_addr_hold: assert property (p_addr_hold) else $error("address changed early");

  property p_fill_update;
    @(posedge mclk_i) disable iff (!reset_n_i)
    ce_i && fill_last |=> tid_q == $past(tid_q) + 8'h01 && contents_q == $past(hist_sel_o);
  endproperty
  a_fill_update: assert property (p_fill_update) else $error("contents or id not updated");

  property p_hist_start;
    @(posedge mclk_i) disable iff (!reset_n_i)
    ce_i && take && is_hist && !stop_pend_q |=> state_q == ST_FILL
      && hist_sel_o == $past(cmd_code_q);
  endproperty
  a_hist_start: assert property (p_hist_start) else $error("histogram quarter not selected");

  property p_refill;
    @(posedge mclk_i) disable iff (!reset_n_i)
    ce_i && show_end && !stop_pend_q |=> state_q == ST_FILL;
  endproperty
  a_refill: assert property (p_refill) else $error("no refill after window read");

  property p_chan_step;
    @(posedge mclk_i) disable iff (!reset_n_i)
    ce_i && show_end && !stop_pend_q && quarter_q == 2'h3 && time_converter_channel_q == 3'h0
      |=> time_converter_channel_q == 3'h1 && quarter_q == 2'h0;
  endproperty
  a_chan_step: assert property (p_chan_step) else $error("channel did not advance");

  property p_stop_waits;
    @(posedge mclk_i) disable iff (!reset_n_i)
    ce_i && state_q == ST_FILL && stop_pend_q && !fill_last |=> state_q == ST_FILL;
  endproperty
  a_stop_waits: assert property (p_stop_waits) else $error("stop broke off fill");

  property p_stop_idle;
    @(posedge mclk_i) disable iff (!reset_n_i)
    ce_i && state_q == ST_SHOW && stop_pend_q |=> state_q == ST_IDLE;
  endproperty
  a_stop_idle: assert property (p_stop_idle) else $error("stop did not reach idle");

  property p_stop_meas;
    @(posedge mclk_i) disable iff (!reset_n_i)
    ce_i && state_q == ST_MEAS && stop_pend_q && meas_done_i |=> state_q == ST_IDLE && !meas_stop_o;
  endproperty
  a_stop_meas: assert property (p_stop_meas) else $error("measurement not stopped");

  property p_last_cmd;
    @(posedge mclk_i) disable iff (!reset_n_i)
    ce_i && take && !stop_pend_q |=> last_command_code_q == $past(cmd_code_q);
  endproperty
  a_last_cmd: assert property (p_last_cmd) else $error("last command not recorded");

endmodule : tofc_command_handler

// ==== hdl/tofc_pin_sync.sv ====
`timescale 1ns/10ps
module tofc_pin_sync
  import tofc_pkg::*;
#(
  parameter int WIDTH = 2
)
(
  input wire logic mclk_i,
  input wire logic reset_n_i,
  input wire logic ce_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  // two stages; the first is read only by the second
  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      meta_q <= '0;
      sync_q <= '0;
    end
    else if (ce_i)
    begin
      meta_q <= async_i;
      sync_q <= meta_q;
    end
  end

  assign sync_o = sync_q;

endmodule : tofc_pin_sync

// ==== hdl/tofc_pkg.sv ====
package tofc_pkg;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [7:0] REG_ARG_SECOND = 8'h0E;
  localparam logic [7:0] REG_ARG_FIRST = 8'h0F;
  localparam logic [7:0] REG_COMMAND = 8'h10;
  localparam logic [7:0] REG_LAST_CMD = 8'h11;
  localparam logic [7:0] REG_MINOR_REV = 8'h12;
  localparam logic [7:0] REG_CONTENTS = 8'h1E;
  localparam logic [7:0] REG_TID = 8'h1F;
  localparam logic [7:0] WIN_FIRST = 8'h20;
  localparam logic [7:0] WIN_LAST = 8'h9F;

  // ---------------------------------------------------------------
  // command codes
  // ---------------------------------------------------------------
  localparam logic [7:0] CMD_ADDR_CHANGE = 8'h49;
  localparam logic [7:0] CMD_HIST_FIRST = 8'h80;
  localparam logic [7:0] CMD_HIST_LAST = 8'h93;
  localparam logic [7:0] CMD_STOP = 8'hFF;

  // ---------------------------------------------------------------
  // field positions and reset values
  // ---------------------------------------------------------------
  localparam int MASK0_BIT = 0;
  localparam int MASK1_BIT = 1;
  localparam int VAL0_BIT = 2;
  localparam int VAL1_BIT = 3;
  localparam int HIST_CH_LSB = 2;
  localparam int HIST_CH_MSB = 4;
  localparam int HIST_Q_MSB = 1;
  localparam int NEW_ADDR_LSB = 1;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [6:0] ADDR_RESET = 7'h41;
  localparam logic [2:0] LAST_CHANNEL = 3'h4;
  localparam logic [1:0] LAST_QUARTER = 2'h3;
  localparam int SYNC_STAGES = 2;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } tofc_reg_req_type;

  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_ADDR = 5'b00010,
    ST_FILL = 5'b00100,
    ST_SHOW = 5'b01000,
    ST_MEAS = 5'b10000
  } tofc_state_type;

endpackage : tofc_pkg

// ==== sim/tb_top.sv ====
`timescale 1ns/10ps
module tb_top;
  import tofc_pkg::*;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic xact = 1'b0;
  logic aux0 = 1'b0;
  logic aux1 = 1'b0;
  tofc_reg_req_type req = '0;
  logic [7:0] rdata, hist_sel, hist_data, meas_cmd, code, nxt, a1;
  logic [6:0] bus_addr, na, exp_addr;
  logic hist_req, hist_ready, hist_valid, meas_start, meas_stop, meas_done, p0, p1;
  logic [7:0] codes [3];
  int n_fail = 0;
  int n_compared = 0;
  int exp_tid, i, k;

  // ---------------------------------------------------------------
  // clock, design and partner
  // ---------------------------------------------------------------
  initial
  begin
    forever #20 mclk = ~mclk;
  end

  tofc_command_handler dut (
    .mclk_i(mclk), .reset_n_i(reset_n), .ce_i(1'b1), .reg_req_i(req),
    .xact_end_i(xact), .rdata_o(rdata), .bus_addr_o(bus_addr),
    .aux_pin_zero_i(aux0), .aux_pin_one_i(aux1), .hist_req_o(hist_req),
    .hist_sel_o(hist_sel), .hist_valid_i(hist_valid), .hist_data_i(hist_data),
    .hist_ready_o(hist_ready), .meas_start_o(meas_start), .meas_cmd_o(meas_cmd),
    .meas_stop_o(meas_stop), .meas_done_i(meas_done));

  tofc_engine_model eng (
    .mclk_i(mclk), .reset_n_i(reset_n), .hist_req_i(hist_ready), .hist_sel_i(hist_sel),
    .meas_start_i(meas_start), .meas_stop_i(meas_stop), .hist_valid_o(hist_valid),
    .hist_data_o(hist_data), .meas_done_o(meas_done));

  // ---------------------------------------------------------------
  // bus tasks and checks
  // ---------------------------------------------------------------
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    req <= '{1'b1, 1'b0, a, d};
    @(posedge mclk);
    req <= '0;
  endtask : wr

  // read data is sampled one extra edge late, it stands until the next read
  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    @(posedge mclk);
    req <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge mclk);
    req <= '0;
    @(posedge mclk);
    #1;
    chk(rdata, e);
  endtask : rdchk

  task automatic pulse_xact();
    @(posedge mclk);
    xact <= 1'b1;
    @(posedge mclk);
    xact <= 1'b0;
  endtask : pulse_xact

  // waits for a whole quarter fill, bounded
  task automatic wait_fill();
    int n;
    n = 0;
    do
    begin
      @(posedge mclk);
      #1;
      n++;
    end while (!hist_req && n < 50);
    do
    begin
      @(posedge mclk);
      #1;
      n++;
    end while (hist_req && n < 2000);
    chk({7'h00, hist_req}, 8'h00);
  endtask : wait_fill

  function automatic logic [7:0] adv(input logic [7:0] c);
    logic [2:0] ch;
    ch = c[4:2];
    if (c[1:0] != 2'h3)
      return c + 8'h01;
    ch = (ch == 3'h4) ? 3'h0 : ch + 3'h1;
    return {3'b100, ch, 2'h0};
  endfunction : adv

  task automatic test_done();
    $display("compared=%0d failed=%0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : test_done

  // watchdog, well beyond the expected few thousand cycles
  initial
  begin
    repeat (60000) @(posedge mclk);
    n_fail++;
    test_done();
  end

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  initial
  begin
    void'($urandom(70));
    exp_tid = 0;
    exp_addr = ADDR_RESET;
    repeat (3) @(posedge mclk);
    reset_n <= 1'b1;
    // register defaults, read-only write and unmapped read
    wr(REG_LAST_CMD, 8'h5A);
    rdchk(REG_LAST_CMD, 8'h00);
    rdchk(REG_MINOR_REV, 8'h01);
    rdchk(8'h05, 8'h00);
    rdchk(REG_TID, 8'h00);
    chk({1'b0, bus_addr}, {1'b0, exp_addr});
    // quarter readout: channel step, channel wrap, random code
    codes = '{8'h83, 8'h93, 8'h80};
    codes[2] = 8'($urandom_range(147, 128));
    for (i = 0; i < 3; i++)
    begin
      code = codes[i];
      wr(REG_COMMAND, code);
      wait_fill();
      exp_tid++;
      rdchk(REG_CONTENTS, code);
      chk(hist_sel, code);
      rdchk(REG_TID, 8'(exp_tid));
      rdchk(REG_LAST_CMD, code);
      rdchk(WIN_FIRST, code);
      k = $urandom_range(127, 0);
      rdchk(8'(32 + k), code ^ 8'(k));
      rdchk(WIN_LAST, code ^ 8'h7F);
      pulse_xact();
      wait_fill();
      exp_tid++;
      nxt = adv(code);
      rdchk(REG_CONTENTS, nxt);
      rdchk(REG_TID, 8'(exp_tid));
      rdchk(WIN_FIRST, nxt);
    end
    // address change; first pass unconditional, upper arg bits kept zero
    for (i = 0; i < 8; i++)
    begin
      // zero first argument on the first pass
      a1 = (i == 0) ? 8'h00 : 8'($urandom_range(15, 0));
      na = 7'($urandom);
      p0 = 1'($urandom);
      p1 = 1'($urandom);
      @(posedge mclk);
      aux0 <= p0;
      aux1 <= p1;
      repeat (4) @(posedge mclk);
      wr(REG_ARG_FIRST, a1);
      // host writes bit 0 as zero
      wr(REG_ARG_SECOND, {na, 1'b0});
      wr(REG_COMMAND, CMD_ADDR_CHANGE);
      repeat (3) @(posedge mclk);
      #1;
      chk({1'b0, bus_addr}, {1'b0, exp_addr});
      pulse_xact();
      @(posedge mclk);
      #1;
      if ({a1[1] & p1, a1[0] & p0} == a1[3:2])
        exp_addr = na;
      chk({1'b0, bus_addr}, {1'b0, exp_addr});
    end
    rdchk(REG_LAST_CMD, CMD_ADDR_CHANGE);
    // running measurement reported, then stopped
    wr(REG_COMMAND, 8'h02);
    repeat (4) @(posedge mclk);
    rdchk(REG_LAST_CMD, 8'h02);
    chk(meas_cmd, 8'h02);
    wr(REG_COMMAND, CMD_STOP);
    #1;
    chk({7'h00, meas_stop}, 8'h01);
    repeat (12) @(posedge mclk);
    #1;
    chk({7'h00, meas_stop}, 8'h00);
    rdchk(REG_LAST_CMD, CMD_STOP);
    // stop in mid-fill lets the quarter complete, then no refill
    wr(REG_COMMAND, 8'h81);
    repeat (8) @(posedge mclk);
    wr(REG_COMMAND, CMD_STOP);
    wait_fill();
    exp_tid++;
    rdchk(REG_CONTENTS, 8'h81);
    rdchk(REG_TID, 8'(exp_tid));
    rdchk(8'h40, 8'h81 ^ 8'h20);
    pulse_xact();
    repeat (6) @(posedge mclk);
    #1;
    chk({7'h00, hist_req}, 8'h00);
    rdchk(REG_LAST_CMD, CMD_STOP);
    test_done();
  end
endmodule : tb_top

// ==== sim/tofc_engine_model.sv ====
`timescale 1ns/10ps
// ---------------------------------------------------------------
// histogram source and measurement engine stand-in
// ---------------------------------------------------------------
module tofc_engine_model
  import tofc_pkg::*;
#(
  parameter int STALL = 1
)
(
  input wire logic mclk_i,
  input wire logic reset_n_i,
  input wire logic hist_req_i,
  input wire logic [7:0] hist_sel_i,
  input wire logic meas_start_i,
  input wire logic meas_stop_i,
  output logic hist_valid_o,
  output logic [7:0] hist_data_o,
  output logic meas_done_o
);
  logic [7:0] idx_q;
  logic run_q;
  logic [1:0] stop_cnt_q;

  // byte source; random stalls so the fill sees a slow producer too
  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      idx_q <= 8'h00;
      hist_valid_o <= 1'b0;
    end
    else
    begin
      if (hist_req_i && hist_valid_o)
        idx_q <= idx_q + 8'h01;
      else if (!hist_req_i)
        idx_q <= 8'h00;
      hist_valid_o <= hist_req_i && ($urandom_range(STALL, 0) == 0);
    end
  end

  // idle data is inverted so a stale byte never looks valid
  assign hist_data_o = hist_valid_o ? (hist_sel_i ^ idx_q) : ~(hist_sel_i ^ idx_q);

  // engine runs until stop has been seen for three cycles
  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      run_q <= 1'b0;
      stop_cnt_q <= 2'h0;
      meas_done_o <= 1'b0;
    end
    else
    begin
      meas_done_o <= 1'b0;
      if (meas_start_i)
        run_q <= 1'b1;
      if (run_q && meas_stop_i)
        stop_cnt_q <= stop_cnt_q + 2'h1;
      if (stop_cnt_q == 2'h3)
      begin
        run_q <= 1'b0;
        stop_cnt_q <= 2'h0;
        meas_done_o <= 1'b1;
      end
    end
  end
endmodule : tofc_engine_model
